/* File: hw/pwm_edges_regs.svh */
/*
 * register offsets, field positions, reset values and timing counts for the
 * pwm edge-placement block.
 * assumes a 32-bit avalon-mm slave with word-aligned byte addresses.
 */
`ifndef PWM_EDGES_REGS_SVH
`define PWM_EDGES_REGS_SVH

`define OFS_CTRL       8'h00
`define OFS_PERIOD     8'h04
`define OFS_EVENT1     8'h08
`define OFS_EVENT2     8'h0C
`define OFS_EVENT3     8'h10
`define OFS_EVENT4     8'h14
`define OFS_ADJ_A      8'h18
`define OFS_ADJ_B      8'h1C
`define OFS_ADAPT      8'h20
`define OFS_PHASE      8'h24
`define OFS_SAMPLE1    8'h28
`define OFS_SAMPLE2    8'h2C
`define OFS_BLANK_AB   8'h30
`define OFS_BLANK_AE   8'h34
`define OFS_BLANK_BB   8'h38
`define OFS_BLANK_BE   8'h3C
`define OFS_STATUS     8'h40

`define CTRL_EN_BIT    0
`define CTRL_MODE_LSB  1
`define CTRL_PHSEL_BIT 4
`define CTRL_ASEL_BIT  5

`define RST_CTRL       32'h0000_0000
`define RST_PERIOD     16'h00FF

`define CLOCK_MHZ      250
`define RDLAT_CYCLES   1

`endif

/* File: hw/pwm_edges_pkg.sv */
/*
 * types for the pwm edge-placement block.
 * assumes 16-bit counts throughout.
 */
package pwm_edges_pkg;
	typedef enum logic [2:0] {
		MODE_NORMAL   = 3'b000,
		MODE_MULTI    = 3'b001,
		MODE_RESONANT = 3'b010,
		MODE_TRIANGLE = 3'b011,
		MODE_LEADING  = 3'b100
	} mode_type;

	typedef enum logic [0:0] {
		BUS_IDLE = 1'b0,
		BUS_ACK  = 1'b1
	} bus_state_type;

	// filter outputs travel together
	typedef struct packed {
		logic [15:0] duty;
		logic [15:0] period;
	} filter_type;

	// everything leaving toward drivers and neighbouring modules
	typedef struct packed {
		logic first_drive_output;
		logic second_drive_output;
		logic adaptive_trig;
		logic phase_trig;
		logic sample_trig1;
		logic sample_trig2;
		logic blank_a;
		logic blank_b;
		logic period_start;
	} pwm_out_type;
endpackage

/* File: hw/pwm_edges.sv */
/*
 * edge-placement logic of one digital pwm module: period counter, mode
 * dependent target computation, drive outputs, triggers and register slave.
 * assumes the compensation filter delivers duty and period on the same clock,
 * and an avalon-mm master that holds each request until waitrequest is low.
 */
//
// Overview of operation
// - period counter counts 0 up to period_limit, then restarts at zero.
// - each output changes one edge after the counter equals its target.
// - normal: A rises at event1, falls at event1+duty+adjust A.
// - normal: B rises at A fall plus (event3-event2), falls at event4.
// - normal/multi/resonant: sample trigger at event1+duty(or half)+offset.
// - phase trigger from fixed phase register or filter duty, selectable.
// - sample triggers 1 and 2 and blanking windows come straight from registers.
// - normal mode ignores adjust B entirely.
// - multi: A as normal, B rises event3, falls event3+duty+adjust B.
// - multi mode ignores event2 and event4.
// - multi: B keeps its width across period wrap; A does not wrap.
// - resonant: dead time 2 = event1+period-event4; average halved sum.
// - resonant: A rises event1, falls event1+duty-average dead time.
// - resonant: B rises A fall+(event3-event2), falls fperiod-(period-event4).
// - triangular: A idle; B centred on half period with adjusts.
// - triangular mode raises no adaptive sample trigger.
// - leading: A falls event1, rises event1-duty+adjust A.
// - leading: B rises event4, falls A rise minus (event2-event3).
// - leading: sample trigger at event1-duty(or half)+offset.
`timescale 1ns/100ps
`include "pwm_edges_regs.svh"

module pwm_edges #(
	parameter int CW = 16
) (
	// clock and reset
	input  wire logic                      clock,
	input  wire logic                      rstn,
	// avalon-mm slave
	input  wire logic [7:0]                address,
	input  wire logic                      read,
	input  wire logic                      write,
	input  wire logic [31:0]               writedata,
	input  wire logic [3:0]                byteenable,
	output logic      [31:0]               readdata,
	output logic                           waitrequest,
	// compensation filter
	input  wire pwm_edges_pkg::filter_type filter,
	// drivers and neighbouring modules
	output pwm_edges_pkg::pwm_out_type     pwm_out
);
	import pwm_edges_pkg::*;

	logic          rst_meta_r;
	logic          rst_r;
	logic [31:0]   ctrl_r;
	logic [CW-1:0] period_limit_r;
	logic [CW-1:0] ev1_r, ev2_r, ev3_r, ev4_r;
	logic [CW-1:0] adj_a_r, adj_b_r, adapt_r, phase_r;
	logic [CW-1:0] smp1_r, smp2_r, bab_r, bae_r, bbb_r, bbe_r;
	logic [CW-1:0] cnt_r;
	logic [CW-1:0] a_rise, a_fall, b_rise, b_fall, trig_t, phase_t;
	logic          trig_on;
	logic          a_on, b_on;
	logic [CW-1:0] dt1, dt2, dt_avg;
	logic [CW-1:0] half_duty, half_prd;
	mode_type      mode;
	bus_state_type bus_r;
	pwm_out_type   out_nxt;

	// reset released through two flops so release is clean on clock
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rst_meta_r <= 1'b0;
			rst_r      <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_r      <= rst_meta_r;
		end
	end

	// byte-lane merge; register widths are cut to the stored width
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) r[i*8 +: 8] = nw[i*8 +: 8];
		end
		return r;
	endfunction

	// low-half merge for the 16-bit registers; upper lanes never reach them
	function automatic logic [CW-1:0] merge_lo(input logic [CW-1:0] old,
			input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] r;
		r = merge({{(32-CW){1'b0}}, old}, nw, be);
		return r[CW-1:0];
	endfunction

	logic wr_take;
	assign wr_take = write && bus_r == BUS_ACK;

	// one wait cycle per access, then acknowledge
	always_ff @(posedge clock or negedge rst_r) begin
		if (!rst_r) begin
			bus_r <= BUS_IDLE;
		end else begin
			case (bus_r)
				BUS_IDLE: bus_r <= (read || write) ? BUS_ACK : BUS_IDLE;
				BUS_ACK:  bus_r <= BUS_IDLE;
				default:  bus_r <= BUS_IDLE;
			endcase
		end
	end
	assign waitrequest = (read || write) && bus_r != BUS_ACK;

	// register writes, taken only at the acknowledging edge
	always_ff @(posedge clock or negedge rst_r) begin
		if (!rst_r) begin
			ctrl_r <= `RST_CTRL;
			period_limit_r <= `RST_PERIOD;
			{ev1_r, ev2_r, ev3_r, ev4_r} <= '0;
			{adj_a_r, adj_b_r, adapt_r, phase_r} <= '0;
			{smp1_r, smp2_r, bab_r, bae_r, bbb_r, bbe_r} <= '0;
		end else if (wr_take) begin
			// status and unmapped offsets fall to default, so writes there are dropped
			case (address)
				`OFS_CTRL:     ctrl_r <= merge(ctrl_r, writedata, byteenable) & 32'h0000_003F;
				`OFS_PERIOD:   period_limit_r <= merge_lo(period_limit_r, writedata, byteenable);
				`OFS_EVENT1:   ev1_r <= merge_lo(ev1_r, writedata, byteenable);
				`OFS_EVENT2:   ev2_r <= merge_lo(ev2_r, writedata, byteenable);
				`OFS_EVENT3:   ev3_r <= merge_lo(ev3_r, writedata, byteenable);
				`OFS_EVENT4:   ev4_r <= merge_lo(ev4_r, writedata, byteenable);
				`OFS_ADJ_A:    adj_a_r <= merge_lo(adj_a_r, writedata, byteenable);
				`OFS_ADJ_B:    adj_b_r <= merge_lo(adj_b_r, writedata, byteenable);
				`OFS_ADAPT:    adapt_r <= merge_lo(adapt_r, writedata, byteenable);
				`OFS_PHASE:    phase_r <= merge_lo(phase_r, writedata, byteenable);
				`OFS_SAMPLE1:  smp1_r <= merge_lo(smp1_r, writedata, byteenable);
				`OFS_SAMPLE2:  smp2_r <= merge_lo(smp2_r, writedata, byteenable);
				`OFS_BLANK_AB: bab_r <= merge_lo(bab_r, writedata, byteenable);
				`OFS_BLANK_AE: bae_r <= merge_lo(bae_r, writedata, byteenable);
				`OFS_BLANK_BB: bbb_r <= merge_lo(bbb_r, writedata, byteenable);
				`OFS_BLANK_BE: bbe_r <= merge_lo(bbe_r, writedata, byteenable);
				default:       ;
			endcase
		end
	end

	// read mux; unmapped offsets read zero
	logic [31:0] rd_nxt;
	always_comb begin
		case (address)
			`OFS_CTRL:     rd_nxt = ctrl_r;
			`OFS_PERIOD:   rd_nxt = {16'h0000, period_limit_r};
			`OFS_EVENT1:   rd_nxt = {16'h0000, ev1_r};
			`OFS_EVENT2:   rd_nxt = {16'h0000, ev2_r};
			`OFS_EVENT3:   rd_nxt = {16'h0000, ev3_r};
			`OFS_EVENT4:   rd_nxt = {16'h0000, ev4_r};
			`OFS_ADJ_A:    rd_nxt = {16'h0000, adj_a_r};
			`OFS_ADJ_B:    rd_nxt = {16'h0000, adj_b_r};
			`OFS_ADAPT:    rd_nxt = {16'h0000, adapt_r};
			`OFS_PHASE:    rd_nxt = {16'h0000, phase_r};
			`OFS_SAMPLE1:  rd_nxt = {16'h0000, smp1_r};
			`OFS_SAMPLE2:  rd_nxt = {16'h0000, smp2_r};
			`OFS_BLANK_AB: rd_nxt = {16'h0000, bab_r};
			`OFS_BLANK_AE: rd_nxt = {16'h0000, bae_r};
			`OFS_BLANK_BB: rd_nxt = {16'h0000, bbb_r};
			`OFS_BLANK_BE: rd_nxt = {16'h0000, bbe_r};
			`OFS_STATUS:   rd_nxt = {14'h0000, pwm_out.second_drive_output,
				pwm_out.first_drive_output, cnt_r};
			default:       rd_nxt = 32'h0000_0000;
		endcase
	end

	// read data registered during the wait cycle, valid at the ack edge
	always_ff @(posedge clock or negedge rst_r) begin
		if (!rst_r) readdata <= 32'h0000_0000;
		else if (read && bus_r == BUS_IDLE) readdata <= rd_nxt;
	end

	// period counter; disabled block holds it at zero
	always_ff @(posedge clock or negedge rst_r) begin
		if (!rst_r) begin
			cnt_r <= '0;
		end else if (!ctrl_r[`CTRL_EN_BIT] || cnt_r >= period_limit_r) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_r + 1'b1;
		end
	end

	// target computation per mode; wrap arithmetic is modulo 2^CW
	assign mode      = mode_type'(ctrl_r[`CTRL_MODE_LSB +: 3]);
	assign half_duty = filter.duty >> 1;
	assign half_prd  = period_limit_r >> 1;
	assign dt1       = ev3_r - ev2_r;
	assign dt2       = ev1_r + period_limit_r - ev4_r;
	assign dt_avg    = CW'(({1'b0, dt1} + {1'b0, dt2}) >> 1);
	assign phase_t   = ctrl_r[`CTRL_PHSEL_BIT] ? filter.duty : phase_r;

	always_comb begin
		a_rise = ev1_r;
		a_fall = ev1_r + filter.duty + adj_a_r;
		b_rise = '0;
		b_fall = '0;
		a_on   = 1'b1;
		trig_on = 1'b1;
		trig_t = ev1_r + (ctrl_r[`CTRL_ASEL_BIT] ? half_duty : filter.duty) + adapt_r;
		case (mode)
			MODE_NORMAL: begin
				b_rise = a_fall + dt1;
				b_fall = ev4_r;
			end
			MODE_MULTI: begin
				b_rise = ev3_r;
				b_fall = ev3_r + filter.duty + adj_b_r;
				// fold a fall target past the limit into the next period so width holds
				if (b_fall > period_limit_r) b_fall = b_fall - period_limit_r - 1'b1;
			end
			MODE_RESONANT: begin
				a_fall = ev1_r + filter.duty - dt_avg;
				b_rise = a_fall + dt1;
				b_fall = filter.period - (period_limit_r - ev4_r);
			end
			MODE_TRIANGLE: begin
				a_on    = 1'b0;
				trig_on = 1'b0;
				b_rise  = half_prd - half_duty + adj_a_r;
				b_fall  = half_prd + half_duty + adj_b_r;
			end
			MODE_LEADING: begin
				a_fall = ev1_r;
				a_rise = ev1_r - filter.duty + adj_a_r;
				b_rise = ev4_r;
				b_fall = a_rise - (ev2_r - ev3_r);
				trig_t = ev1_r - (ctrl_r[`CTRL_ASEL_BIT] ? half_duty : filter.duty) + adapt_r;
			end
			default: begin
				a_on    = 1'b0;
				trig_on = 1'b0;
			end
		endcase
	end

	// next output state: set/clear on exact counter matches
	always_comb begin
		out_nxt = pwm_out;
		if (!ctrl_r[`CTRL_EN_BIT] || !a_on) out_nxt.first_drive_output = 1'b0;
		else if (cnt_r == a_fall)           out_nxt.first_drive_output = 1'b0;
		else if (cnt_r == a_rise)           out_nxt.first_drive_output = 1'b1;
		// normal mode: A restarts low each period unless event1 is zero; an equal fall target still wins
		if (ctrl_r[`CTRL_EN_BIT] && mode == MODE_NORMAL && cnt_r == '0 && a_fall != '0)
			out_nxt.first_drive_output = ev1_r == '0;
		// B uses pure toggle points so a wrapped pulse keeps its width
		if (!ctrl_r[`CTRL_EN_BIT])          out_nxt.second_drive_output = 1'b0;
		else if (cnt_r == b_rise)           out_nxt.second_drive_output = 1'b1;
		else if (cnt_r == b_fall)           out_nxt.second_drive_output = 1'b0;
		out_nxt.adaptive_trig = ctrl_r[`CTRL_EN_BIT] && trig_on && cnt_r == trig_t;
		out_nxt.phase_trig    = ctrl_r[`CTRL_EN_BIT] && cnt_r == phase_t;
		out_nxt.sample_trig1  = ctrl_r[`CTRL_EN_BIT] && cnt_r == smp1_r;
		out_nxt.sample_trig2  = ctrl_r[`CTRL_EN_BIT] && cnt_r == smp2_r;
		if (cnt_r == bab_r) out_nxt.blank_a = 1'b1;
		if (cnt_r == bae_r) out_nxt.blank_a = 1'b0;
		if (cnt_r == bbb_r) out_nxt.blank_b = 1'b1;
		if (cnt_r == bbe_r) out_nxt.blank_b = 1'b0;
		out_nxt.period_start  = ctrl_r[`CTRL_EN_BIT] && cnt_r == '0;
	end

	// outputs from flops: each shows the match one edge after the count
	always_ff @(posedge clock or negedge rst_r) begin
		if (!rst_r) pwm_out <= '0;
		else        pwm_out <= out_nxt;
	end

	// counter restarts at zero the edge after it reaches or passes the limit
	cnt_bound_a: assert property (@(posedge clock) disable iff (!rst_r)
		ctrl_r[`CTRL_EN_BIT] && cnt_r >= period_limit_r |=> cnt_r == '0)
		else $error("counter did not restart at limit");

	sequence a_hits_rise;
		ctrl_r[`CTRL_EN_BIT] && a_on && cnt_r == a_rise && cnt_r != a_fall
			&& !(mode == MODE_NORMAL && cnt_r == '0);
	endsequence
	drive_a_rise_a: assert property (@(posedge clock) disable iff (!rst_r)
		a_hits_rise |=> pwm_out.first_drive_output)
		else $error("output A missed its rising target");

	drive_a_fall_a: assert property (@(posedge clock) disable iff (!rst_r)
		a_on && cnt_r == a_fall |=> !pwm_out.first_drive_output)
		else $error("output A missed its falling target");

	tri_a_idle_a: assert property (@(posedge clock) disable iff (!rst_r)
		mode == MODE_TRIANGLE |=> !pwm_out.first_drive_output)
		else $error("output A active in triangular mode");

	tri_no_trig_a: assert property (@(posedge clock) disable iff (!rst_r)
		mode == MODE_TRIANGLE && $past(mode) == MODE_TRIANGLE |-> !pwm_out.adaptive_trig)
		else $error("adaptive trigger in triangular mode");

	drive_b_rise_a: assert property (@(posedge clock) disable iff (!rst_r)
		ctrl_r[`CTRL_EN_BIT] && cnt_r == b_rise |=> pwm_out.second_drive_output)
		else $error("output B missed its rising target");

	sample_fixed_a: assert property (@(posedge clock) disable iff (!rst_r)
		ctrl_r[`CTRL_EN_BIT] && cnt_r == smp1_r |=> pwm_out.sample_trig1)
		else $error("sample trigger 1 missed its register value");

	phase_sel_a: assert property (@(posedge clock) disable iff (!rst_r)
		ctrl_r[`CTRL_EN_BIT] && cnt_r == phase_t |=> pwm_out.phase_trig)
		else $error("phase trigger missed its selected source");

	// counter restarts and flags the period start one edge later
	sequence period_wrap;
		ctrl_r[`CTRL_EN_BIT] && cnt_r >= period_limit_r ##1 ctrl_r[`CTRL_EN_BIT] && cnt_r == '0;
	endsequence
	period_pulse_a: assert property (@(posedge clock) disable iff (!rst_r)
		period_wrap |=> pwm_out.period_start)
		else $error("period start pulse missing after wrap");

	cnt_hold_a: assert property (@(posedge clock) disable iff (!rst_r)
		!ctrl_r[`CTRL_EN_BIT] |=> cnt_r == '0)
		else $error("counter ran while disabled");

	// a disabled block must leave the power stage switched off
	drive_off_a: assert property (@(posedge clock) disable iff (!rst_r)
		!ctrl_r[`CTRL_EN_BIT] |=> !pwm_out.first_drive_output && !pwm_out.second_drive_output
			&& !pwm_out.adaptive_trig && !pwm_out.phase_trig && !pwm_out.period_start)
		else $error("outputs active while disabled");

	sequence b_hits_fall;
		ctrl_r[`CTRL_EN_BIT] && cnt_r == b_fall && cnt_r != b_rise;
	endsequence
	drive_b_fall_a: assert property (@(posedge clock) disable iff (!rst_r)
		b_hits_fall |=> !pwm_out.second_drive_output)
		else $error("output B missed its falling target");

	adapt_trig_a: assert property (@(posedge clock) disable iff (!rst_r)
		ctrl_r[`CTRL_EN_BIT] && trig_on && cnt_r == trig_t |=> pwm_out.adaptive_trig)
		else $error("adaptive trigger missed its target");

	sample2_fixed_a: assert property (@(posedge clock) disable iff (!rst_r)
		ctrl_r[`CTRL_EN_BIT] && cnt_r == smp2_r |=> pwm_out.sample_trig2)
		else $error("sample trigger 2 missed its register value");

	blank_a_end_a: assert property (@(posedge clock) disable iff (!rst_r)
		cnt_r == bae_r |=> !pwm_out.blank_a)
		else $error("blanking A did not end at its register value");

	blank_b_set_a: assert property (@(posedge clock) disable iff (!rst_r)
		cnt_r == bbb_r && cnt_r != bbe_r |=> pwm_out.blank_b)
		else $error("blanking B did not begin at its register value");
endmodule

/* File: verification/filter_model.sv */
/*
 * stand-in for the compensation filter that feeds the edge block.
 * assumes one clock shared with the edge block and a bench that sets demand.
 */
`timescale 1ns/100ps

module filter_model (
	// clock and reset
	input  wire logic                 clock,
	input  wire logic                 rstn,
	// demand from the bench
	input  wire logic [15:0]          duty_req,
	input  wire logic                 resonant,
	// toward the edge block
	output pwm_edges_pkg::filter_type filter
);
	import pwm_edges_pkg::*;

	// one register stage, like a real filter output; period is junk outside resonance
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			filter <= '0;
		end else begin
			filter.duty   <= duty_req;
			filter.period <= resonant ? {duty_req[14:0], 1'b0} : 16'hFFFF;
		end
	end
endmodule

/* File: verification/digital_pwm_mode_edges_tb_top.sv */
/*
 * self-checking bench: edge offsets within a period against a model.
 * assumes the edge block, its register header and the filter model.
 */
`timescale 1ns/100ps
`include "pwm_edges_regs.svh"

module digital_pwm_mode_edges_tb_top;
	import pwm_edges_pkg::*;
	localparam int P = 300;
	logic        clock, rstn, read, write, waitrequest, resonant;
	logic [7:0]  address;
	logic [31:0] writedata, readdata, rd;
	logic [3:0]  byteenable;
	logic [15:0] duty_req;
	filter_type  filter;
	pwm_out_type pwm_out;
	int          errors, checked, m, i, d, sd;
	int          got[12], exp[12];

	// free-running clock
	always #2 clock = ~clock;

	pwm_edges i_pwm_edges (.clock(clock), .rstn(rstn), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .filter(filter), .pwm_out(pwm_out));
	filter_model i_filter_model (.clock(clock), .rstn(rstn), .duty_req(duty_req),
		.resonant(resonant), .filter(filter));

	task conclude;
		$display("errors=%0d checked=%0d", errors, checked);
		if (errors == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task cmp_edge(input int g, input int e);
		checked++;
		if (g != e) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task cmp_word(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	// one avalon access; held until waitrequest is seen low at an edge
	task bus(input logic wr, input logic [7:0] a, input logic [31:0] dat);
		int n;
		@(posedge clock);
		address    <= a;
		writedata  <= dat;
		byteenable <= 4'hF;
		if (wr) write <= 1'b1;
		else read <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clock);
			if (waitrequest === 1'b0) break;
		end
		rd = readdata;
		write <= 1'b0;
		read  <= 1'b0;
		if (n == 50) begin
			errors++;
			conclude();
		end
	endtask

	// offsets from period start; several starts skipped so new settings have landed
	task measure;
		int n, k;
		pwm_out_type p, q;
		for (k = 0; k < 12; k++) got[k] = -1;
		for (n = 0; n < 3; n++) begin
			for (k = 0; k < 1000; k++) begin
				@(posedge clock);
				#1;
				if (pwm_out.period_start === 1'b1) break;
			end
			if (k == 1000) begin
				errors++;
				conclude();
			end
		end
		q = pwm_out;
		for (k = 1; k <= P; k++) begin
			@(posedge clock);
			#1;
			p = pwm_out;
			if (p.first_drive_output !== q.first_drive_output)
				got[(p.first_drive_output === 1'b1) ? 0 : 1] = k;
			if (p.second_drive_output !== q.second_drive_output)
				got[(p.second_drive_output === 1'b1) ? 2 : 3] = k;
			if (p.adaptive_trig === 1'b1) got[4] = k;
			if (p.phase_trig === 1'b1) got[5] = k;
			if (p.sample_trig1 === 1'b1) got[6] = k;
			if (p.blank_a !== q.blank_a) got[(p.blank_a === 1'b1) ? 7 : 8] = k;
			if (p.sample_trig2 === 1'b1) got[9] = k;
			if (p.blank_b !== q.blank_b) got[(p.blank_b === 1'b1) ? 10 : 11] = k;
			q = p;
		end
	endtask

	// expected offsets from period start; -1 means no event; a period is limit plus one
	task model(input int md, input int du, input bit ph, input bit as);
		int hd, ed;
		hd = as ? du / 2 : du;
		ed = 120 + du + 3;
		exp[5] = ph ? du : 33;
		exp[6] = 50;
		exp[7] = 30;
		exp[8] = 40;
		exp[9] = 60;
		exp[10] = 70;
		exp[11] = 80;
		exp[0] = 120;
		exp[1] = ed;
		exp[4] = 120 + hd + 7;
		case (md)
			0: begin
				exp[2] = ed + 5;
				exp[3] = 290;
			end
			1: begin
				exp[2] = 280;
				exp[3] = (280 + du + 5) % 301;
			end
			2: begin
				exp[1] = 120 + du - ((25 - 20) + (120 + 300 - 290)) / 2;
				exp[2] = exp[1] + (25 - 20);
				exp[3] = 2 * du - 10;
			end
			3: begin
				exp[0] = -1;
				exp[1] = -1;
				exp[2] = 150 - du / 2 + 3;
				exp[3] = 150 + du / 2 + 5;
				exp[4] = -1;
			end
			4: begin
				exp[0] = 120 - du + 3;
				exp[1] = 120;
				exp[2] = 290;
				exp[3] = exp[0] + 5;
				exp[4] = 120 - hd + 7;
			end
			default: begin
				exp[0] = -1;
				exp[1] = -1;
				exp[2] = -1;
				exp[3] = -1;
				exp[4] = -1;
			end
		endcase
	endtask

	initial begin
		clock = 1'b0;
		rstn = 1'b0;
		read = 1'b0;
		write = 1'b0;
		address = 8'h00;
		writedata = 32'h0000_0000;
		byteenable = 4'h0;
		duty_req = 16'h0040;
		resonant = 1'b0;
		errors = 0;
		checked = 0;
		sd = $urandom(32'hC2373838);
		repeat (3) @(posedge clock);
		rstn <= 1'b1;
		repeat (5) @(posedge clock);
		bus(1'b0, `OFS_PERIOD, 32'h0);
		cmp_word(rd, {16'h0000, `RST_PERIOD});
		bus(1'b0, 8'h80, 32'h0);
		cmp_word(rd, 32'h0000_0000);
		bus(1'b1, `OFS_PERIOD, 32'h0000_012C);
		bus(1'b1, `OFS_EVENT1, 32'h0000_0078);
		bus(1'b1, `OFS_ADJ_A, 32'h0000_0003);
		bus(1'b1, `OFS_ADJ_B, 32'h0000_0005);
		bus(1'b1, `OFS_ADAPT, 32'h0000_0007);
		bus(1'b1, `OFS_PHASE, 32'h0000_0021);
		bus(1'b1, `OFS_SAMPLE1, 32'h0000_0032);
		bus(1'b1, `OFS_BLANK_AB, 32'h0000_001E);
		bus(1'b1, `OFS_BLANK_AE, 32'h0000_0028);
		bus(1'b1, `OFS_SAMPLE2, 32'h0000_003C);
		bus(1'b1, `OFS_BLANK_BB, 32'h0000_0046);
		bus(1'b1, `OFS_BLANK_BE, 32'h0000_0050);
		bus(1'b0, `OFS_EVENT1, 32'h0);
		cmp_word(rd, 32'h0000_0078);
		// every mode plus a reserved code, random even duty; multi mode gets junk in
		// events 2 and 4 and a late event 3 so that B wraps across the period end
		for (m = 0; m < 6; m++) begin
			d = 40 + 2 * ($urandom % 20);
			@(posedge clock);
			duty_req <= d[15:0];
			resonant <= (m == 2);
			bus(1'b1, `OFS_EVENT2, (m == 1) ? 32'h0000_004D : 32'h0000_0014);
			bus(1'b1, `OFS_EVENT4, (m == 1) ? 32'h0000_004D : 32'h0000_0122);
			bus(1'b1, `OFS_EVENT3, (m == 1) ? 32'h0000_0118 : 32'h0000_0019);
			bus(1'b1, `OFS_CTRL, 32'(1 + 2 * m + 16 * (m % 2) + 32 * int'(m == 1 || m == 4)));
			measure();
			model(m, d, m % 2, m == 1 || m == 4);
			for (i = 0; i < 12; i++) cmp_edge(got[i], exp[i]);
		end
		conclude();
	end
endmodule
